// ### rtl/hia_pkg.sv
// Package of constants and carrier types for the host interrupt aggregator
package hia_pkg;

    // Register offsets on the host register port
    localparam logic [7:0] HIA_OFS_MASK0   = 8'h30;
    localparam logic [7:0] HIA_OFS_MASK1   = 8'h31;
    localparam logic [7:0] HIA_OFS_VIEW0   = 8'h40;
    localparam logic [7:0] HIA_OFS_VIEW1   = 8'h41;
    localparam logic [7:0] HIA_OFS_LPCOPY  = 8'h42;
    localparam logic [7:0] HIA_OFS_CLR0    = 8'h43;
    localparam logic [7:0] HIA_OFS_CLR1    = 8'h44;

    // Bit positions, group 0
    localparam int HIA_BIT_ALARM    = 4;
    localparam int HIA_BIT_OSCFAIL  = 3;
    localparam int HIA_BIT_PINMATCH = 0;
    // Bit positions, group 1
    localparam int HIA_BIT_INITDONE = 4;
    localparam int HIA_BIT_T1WRAP   = 3;
    localparam int HIA_BIT_T0WRAP   = 2;

    // Implemented flag bits per group
    localparam logic [7:0] HIA_G0_BITS     = 8'h19;
    localparam logic [7:0] HIA_G1_BITS     = 8'h1c;
    // Clock flags held while their low power copy is set
    localparam logic [7:0] HIA_RTC_BITS    = 8'h18;

    // Values after reset
    localparam logic [7:0] HIA_PEND0_RST   = 8'h00;
    localparam logic [7:0] HIA_PEND1_RST   = 8'h04;
    localparam logic [7:0] HIA_MASK0_RST   = 8'h31;
    localparam logic [7:0] HIA_MASK1_RST   = 8'h1c;
    localparam logic [7:0] HIA_LPCOPY_RST  = 8'h00;

    // Mask 0 and mask 1 storage bits, mask 0 fixed read-as-one bits
    localparam logic [7:0] HIA_MASK0_RW    = 8'h39;
    localparam logic [7:0] HIA_MASK0_ONES  = 8'hc6;
    localparam logic [7:0] HIA_MASK1_RW    = 8'h1c;

    // Host register access, one request per cycle
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hia_reg_req_t;

    // Event pulses from the device core, one cycle each
    typedef struct packed {
        logic clock_alarm;
        logic osc_failure;
        logic pin_match;
        logic timer1_wrap;
        logic clock_capture;
        logic timer0_wrap;
    } hia_events_t;

endpackage

// ### rtl/hia_flag_cell.sv
// One sticky pending flag with set-over-clear priority
`timescale 1ns/100ps
module hia_flag_cell #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);

    logic flag_ff;
    logic nxt_flag;

    // Set wins so an event landing on a clearing read survives
    assign nxt_flag = set | (flag_ff & ~clr);

    // Flag storage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_ff <= RESET_VAL;
        else
            flag_ff <= nxt_flag;
    end

    assign flag = flag_ff;

endmodule

// ### rtl/hia_top.sv
// Host interrupt aggregator: pending, mask, mirror and low power copy registers
//
// Behaviour
// - Event sets pending flag, enabled drives alert low
// - Alert held while any enabled flag pending
// - Clearing read returns flags then clears them
// - Cleared enable bit removes source from alert
// - Enabled clock events copied; copy blocks clear
// - Mirror registers read flags without clearing
// - Clock alarm sets group 0 bit 4
// - Oscillator failure sets group 0 bit 3
// - Pin match sets group 0 bit 0
// - Initialisation done sets group 1 bit 4
// - Timer 1 wrap or capture sets bit 3
// - Timer 0 wrap sets group 1 bit 2
// - Mask registers at 0x30 and 0x31
// - Mirror registers at 0x40 and 0x41
`timescale 1ns/100ps
module hia_top (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire hia_pkg::hia_reg_req_t reg_req,
    input  wire hia_pkg::hia_events_t  events,
    input  wire logic                  init_done,
    output logic [7:0]                 rdata,
    output logic                       alert_n
);
    import hia_pkg::*;

    logic [7:0] pend0;
    logic [7:0] pend1;
    logic [7:0] mask0_ff;
    logic [7:0] mask1_ff;
    logic [7:0] lpcopy_ff;
    logic [7:0] rdata_ff;
    logic       alert_n_ff;
    logic       init_seen_ff;

    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic [7:0] lp_set;
    logic [7:0] nxt_mask0;
    logic [7:0] nxt_mask1;
    logic [7:0] nxt_lpcopy;
    logic [7:0] nxt_rdata;
    logic       nxt_alert_n;
    logic       init_rise;
    logic       any_enabled;

    // Address decode
    wire rd_clr0  = reg_req.rd && (reg_req.addr == HIA_OFS_CLR0);
    wire rd_clr1  = reg_req.rd && (reg_req.addr == HIA_OFS_CLR1);
    wire rd_view0 = reg_req.rd && (reg_req.addr == HIA_OFS_VIEW0);
    wire rd_view1 = reg_req.rd && (reg_req.addr == HIA_OFS_VIEW1);
    wire wr_mask0 = reg_req.wr && (reg_req.addr == HIA_OFS_MASK0);
    wire wr_mask1 = reg_req.wr && (reg_req.addr == HIA_OFS_MASK1);
    wire wr_lp    = reg_req.wr && (reg_req.addr == HIA_OFS_LPCOPY);

    // Init done is a level; only its rising edge raises the flag
    assign init_rise = init_done & ~init_seen_ff;

    // Event routing onto flag positions
    assign set0 = (8'(events.clock_alarm) << HIA_BIT_ALARM)
                | (8'(events.osc_failure) << HIA_BIT_OSCFAIL)
                | (8'(events.pin_match) << HIA_BIT_PINMATCH);
    assign set1 = (8'(init_rise) << HIA_BIT_INITDONE)
                | (8'(events.timer1_wrap | events.clock_capture) << HIA_BIT_T1WRAP)
                | (8'(events.timer0_wrap) << HIA_BIT_T0WRAP);

    // Clearing reads; clock flags held while their copy is set
    assign clr0 = rd_clr0 ? ~(lpcopy_ff & HIA_RTC_BITS) : 8'h00;
    assign clr1 = rd_clr1 ? 8'hff : 8'h00;

    // Flag cells, only where a source exists; other bits read zero
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_flags
            if (HIA_G0_BITS[gi])
            begin : g_f0
                hia_flag_cell #(
                    .RESET_VAL (HIA_PEND0_RST[gi])
                ) u_f0 (
                    .clk   (clk),
                    .rst_n (rst_n),
                    .set   (set0[gi]),
                    .clr   (clr0[gi]),
                    .flag  (pend0[gi])
                );
            end
            else
            begin : g_z0
                assign pend0[gi] = 1'b0;
            end
            if (HIA_G1_BITS[gi])
            begin : g_f1
                hia_flag_cell #(
                    .RESET_VAL (HIA_PEND1_RST[gi])
                ) u_f1 (
                    .clk   (clk),
                    .rst_n (rst_n),
                    .set   (set1[gi]),
                    .clr   (clr1[gi]),
                    .flag  (pend1[gi])
                );
            end
            else
            begin : g_z1
                assign pend1[gi] = 1'b0;
            end
        end
    endgenerate

    // Low power copy: enabled clock events set, host write of zero clears
    assign lp_set     = set0 & mask0_ff & HIA_RTC_BITS;
    assign nxt_lpcopy = lp_set | (wr_lp ? (lpcopy_ff & reg_req.wdata) : lpcopy_ff);

    // Mask registers keep only their storable bits
    assign nxt_mask0 = wr_mask0 ? (reg_req.wdata & HIA_MASK0_RW) : mask0_ff;
    assign nxt_mask1 = wr_mask1 ? (reg_req.wdata & HIA_MASK1_RW) : mask1_ff;

    // Read mux; unmapped offsets read zero
    assign nxt_rdata = (rd_clr0 || rd_view0) ? pend0 :
                       (rd_clr1 || rd_view1) ? pend1 :
                       (reg_req.rd && reg_req.addr == HIA_OFS_MASK0) ? (mask0_ff | HIA_MASK0_ONES) :
                       (reg_req.rd && reg_req.addr == HIA_OFS_MASK1) ? mask1_ff :
                       (reg_req.rd && reg_req.addr == HIA_OFS_LPCOPY) ? lpcopy_ff :
                       reg_req.rd ? 8'h00 : rdata_ff;

    // Alert from enabled pending flags only
    assign any_enabled = |(pend0 & mask0_ff & HIA_G0_BITS)
                       | |(pend1 & mask1_ff & HIA_G1_BITS);
    assign nxt_alert_n = ~any_enabled;

    // Control and status registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask0_ff     <= HIA_MASK0_RST;
            mask1_ff     <= HIA_MASK1_RST;
            lpcopy_ff    <= HIA_LPCOPY_RST;
            init_seen_ff <= 1'b0;
        end
        else
        begin
            mask0_ff     <= nxt_mask0;
            mask1_ff     <= nxt_mask1;
            lpcopy_ff    <= nxt_lpcopy;
            init_seen_ff <= init_done;
        end
    end

    // Output registers; read data holds until the next read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_ff   <= 8'h00;
            alert_n_ff <= 1'b1;
        end
        else
        begin
            rdata_ff   <= nxt_rdata;
            alert_n_ff <= nxt_alert_n;
        end
    end

    assign rdata   = rdata_ff;
    assign alert_n = alert_n_ff;

    // Alert follows enabled pending flags one cycle later
    a_alert_follows: assert property (@(posedge clk) disable iff (!rst_n)
        any_enabled |=> !alert_n)
        else $error("alert not asserted for enabled pending flag");

    // Masked flags alone never pull the alert
    a_mask_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        !any_enabled |=> alert_n)
        else $error("alert asserted with no enabled flag pending");

    // Clearing read returns the flags held before the edge
    a_rd_returns: assert property (@(posedge clk) disable iff (!rst_n)
        rd_clr0 |=> rdata == $past(pend0))
        else $error("clearing read returned wrong flags");

    // Group 1 clearing read with no new events empties it
    a_rd_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_clr1 && set1 == 8'h00) |=> pend1 == 8'h00)
        else $error("group 1 flags not cleared by read");

    // Mirror reads never drop a flag
    a_mirror_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_view0 || rd_view1) |=> (($past(pend0) & ~pend0) == 8'h00) && (($past(pend1) & ~pend1) == 8'h00))
        else $error("mirror read cleared a flag");

    // Clock alarm flag held by its copy across a clearing read
    a_lp_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_clr0 && lpcopy_ff[HIA_BIT_ALARM] && pend0[HIA_BIT_ALARM]) |=> pend0[HIA_BIT_ALARM])
        else $error("clock alarm flag cleared while copy set");

    // Enabled alarm lands in the low power copy
    a_lp_copy: assert property (@(posedge clk) disable iff (!rst_n)
        (events.clock_alarm && mask0_ff[HIA_BIT_ALARM]) |=> lpcopy_ff[HIA_BIT_ALARM])
        else $error("enabled alarm missing from low power copy");

    // Each source sets its own flag
    a_alarm_bit: assert property (@(posedge clk) disable iff (!rst_n)
        events.clock_alarm |=> pend0[4])
        else $error("alarm did not set group 0 bit 4");
    a_fail_bit: assert property (@(posedge clk) disable iff (!rst_n)
        events.osc_failure |=> pend0[3])
        else $error("oscillator failure did not set group 0 bit 3");
    a_match_bit: assert property (@(posedge clk) disable iff (!rst_n)
        events.pin_match |=> pend0[0])
        else $error("pin match did not set group 0 bit 0");
    a_init_bit: assert property (@(posedge clk) disable iff (!rst_n)
        (init_done && !$past(init_done)) |=> pend1[4])
        else $error("init done did not set group 1 bit 4");
    a_t1_bit: assert property (@(posedge clk) disable iff (!rst_n)
        (events.timer1_wrap || events.clock_capture) |=> pend1[3])
        else $error("timer 1 event did not set group 1 bit 3");

    // Timer 0 wrap survives a clearing read in the same cycle
    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        events.timer0_wrap |=> pend1[2] ##1 (pend1[2] || $past(rd_clr1)))
        else $error("timer 0 wrap lost");

    // Read data stands until the next read of any kind
    a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_req.rd |=> $stable(rdata))
        else $error("read data changed without a read");

    // Mirror reads return the flags held before the edge
    a_view0_data: assert property (@(posedge clk) disable iff (!rst_n)
        rd_view0 |=> rdata == $past(pend0))
        else $error("group 0 mirror returned wrong flags");
    a_view1_data: assert property (@(posedge clk) disable iff (!rst_n)
        rd_view1 |=> rdata == $past(pend1))
        else $error("group 1 mirror returned wrong flags");

    // Group 1 clearing read returns its flags
    a_clr1_data: assert property (@(posedge clk) disable iff (!rst_n)
        rd_clr1 |=> rdata == $past(pend1))
        else $error("group 1 clearing read returned wrong flags");

    // Group 0 clearing read with no event and no copy empties it
    a_clr0_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_clr0 && set0 == 8'h00 && (lpcopy_ff & HIA_RTC_BITS) == 8'h00) |=> pend0 == 8'h00)
        else $error("group 0 flags not cleared by read");

    // Oscillator failure flag held by its copy across a clearing read
    a_fail_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_clr0 && lpcopy_ff[HIA_BIT_OSCFAIL] && pend0[HIA_BIT_OSCFAIL]) |=> pend0[HIA_BIT_OSCFAIL])
        else $error("oscillator failure flag cleared while copy set");

    // Enabled oscillator failure lands in the low power copy
    a_fail_copy: assert property (@(posedge clk) disable iff (!rst_n)
        (events.osc_failure && mask0_ff[HIA_BIT_OSCFAIL]) |=> lpcopy_ff[HIA_BIT_OSCFAIL])
        else $error("enabled oscillator failure missing from low power copy");

    // A masked alarm never raises its copy bit
    a_copy_masked: assert property (@(posedge clk) disable iff (!rst_n)
        (!lpcopy_ff[HIA_BIT_ALARM] && !(events.clock_alarm && mask0_ff[HIA_BIT_ALARM]))
        |=> !lpcopy_ff[HIA_BIT_ALARM])
        else $error("low power copy set without an enabled alarm");

    // Host write to the copy only clears bits when no clock event lands
    a_copy_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_lp && !events.clock_alarm && !events.osc_failure)
        |=> lpcopy_ff == ($past(lpcopy_ff) & $past(reg_req.wdata)))
        else $error("low power copy write gave wrong value");

    // Mask 0 write keeps only its storable bits
    a_mask0_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_mask0 |=> mask0_ff == ($past(reg_req.wdata) & HIA_MASK0_RW))
        else $error("mask 0 write stored wrong value");

    // Mask 1 write keeps only bits with a source
    a_mask1_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_mask1 |=> mask1_ff == ($past(reg_req.wdata) & HIA_MASK1_RW))
        else $error("mask 1 write stored wrong value");

    // Mask 0 reads back with its fixed ones
    a_mask0_read: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_req.rd && reg_req.addr == HIA_OFS_MASK0)
        |=> rdata == ($past(mask0_ff) | HIA_MASK0_ONES))
        else $error("mask 0 read returned wrong value");

    // Events racing a clearing read in either group survive
    a_race_g0: assert property (@(posedge clk) disable iff (!rst_n)
        (events.pin_match && rd_clr0) |=> pend0[HIA_BIT_PINMATCH])
        else $error("pin match lost on clearing read");
    a_race_g1: assert property (@(posedge clk) disable iff (!rst_n)
        (events.timer1_wrap && rd_clr1) |=> pend1[HIA_BIT_T1WRAP])
        else $error("timer 1 wrap lost on clearing read");

    // Clock capture shares the timer 1 flag
    a_capture_bit: assert property (@(posedge clk) disable iff (!rst_n)
        events.clock_capture |=> pend1[HIA_BIT_T1WRAP])
        else $error("clock capture did not set group 1 bit 3");

    // Init done held high raises its flag only once
    a_init_once: assert property (@(posedge clk) disable iff (!rst_n)
        (!pend1[HIA_BIT_INITDONE] && !(init_done && !$past(init_done))) |=> !pend1[HIA_BIT_INITDONE])
        else $error("init done flag raised without a rising edge");

endmodule

// ### tb/hia_host_model.sv
// Host processor model driving the register port of the aggregator
`timescale 1ns/100ps
module hia_host_model (
    input  wire logic          clk,
    input  wire logic [7:0]    rdata,
    output hia_pkg::hia_reg_req_t req
);
    import hia_pkg::*;

    // Port idle from time zero
    initial req = '0;

    // Request held up to the taking edge, data taken after it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge clk);
        req <= '0;
    endtask

    // Copy cleared first, else the clock flags stick
    task automatic clear_clock(output logic [7:0] d);
        wr(HIA_OFS_LPCOPY, 8'h00);
        rd(HIA_OFS_CLR0, d);
    endtask

    // Polling through the mirrors leaves the flags alone
    task automatic poll(output logic [7:0] g0, output logic [7:0] g1);
        rd(HIA_OFS_VIEW0, g0);
        rd(HIA_OFS_VIEW1, g1);
    endtask
endmodule

// ### tb/hia_top_tb_top.sv
// Self-checking bench for the host interrupt aggregator
`timescale 1ns/100ps
module hia_top_tb_top;
    import hia_pkg::*;
    logic         clk;
    logic         rst_n;
    hia_reg_req_t reg_req;
    hia_events_t  events;
    logic         init_done;
    logic [7:0]   rdata;
    logic         alert_n;
    logic [7:0]   d;
    int           fail_count;
    int           n_checks;

    hia_top u_hia_top (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .events(events),
                       .init_done(init_done), .rdata(rdata), .alert_n(alert_n));
    hia_host_model u_hia_host_model (.clk(clk), .rdata(rdata), .req(reg_req));

    // Free running 100 ns clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare helpers, one per kind of result
    task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_hia_host_model.rd(a, d);
        chk_byte($sformatf("reg %h", a), exp, d);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // One-cycle event pulse, returns at its taking edge
    task automatic fire(input hia_events_t e);
        @(posedge clk);
        events <= e;
        @(posedge clk);
        events <= '0;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Values after reset, unmapped read, first clearing read
    task automatic t_reset;
        chk_bit("alert_n", 1'b0, alert_n);
        rchk(HIA_OFS_MASK0, 8'hf7);
        rchk(HIA_OFS_MASK1, 8'h1c);
        rchk(HIA_OFS_VIEW1, 8'h04);
        rchk(HIA_OFS_VIEW1, 8'h04);
        rchk(HIA_OFS_VIEW0, 8'h00);
        rchk(HIA_OFS_LPCOPY, 8'h00);
        rchk(8'h55, 8'h00);
        rchk(HIA_OFS_CLR1, 8'h04);
        rchk(HIA_OFS_VIEW1, 8'h00);
        chk_bit("alert_n", 1'b1, alert_n);
    endtask

    // Each plain source alone; the oscillator fail is masked at reset
    task automatic t_sources;
        logic [5:0] ev [5] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
        logic [7:0] fl [5] = '{8'h08, 8'h01, 8'h08, 8'h08, 8'h04};
        logic [7:0] g;
        for (int i = 0; i < 5; i++)
        begin
            g = (i < 2) ? 8'h00 : 8'h01;
            fire(ev[i]);
            settle(1);
            chk_bit("alert_n", i == 0, alert_n);
            rchk(HIA_OFS_VIEW0 + g, fl[i]);
            rchk(HIA_OFS_CLR0 + g, fl[i]);
            rchk(HIA_OFS_VIEW0 + g, 8'h00);
            chk_bit("alert_n", 1'b1, alert_n);
        end
    endtask

    // Alarm sticks until its low power copy is cleared
    task automatic t_alarm;
        logic [7:0] g0;
        logic [7:0] g1;
        fire(6'h20);
        settle(1);
        chk_bit("alert_n", 1'b0, alert_n);
        rchk(HIA_OFS_LPCOPY, 8'h10);
        rchk(HIA_OFS_CLR0, 8'h10);
        u_hia_host_model.poll(g0, g1);
        chk_byte("view0", 8'h10, g0);
        chk_byte("view1", 8'h00, g1);
        chk_bit("alert_n", 1'b0, alert_n);
        u_hia_host_model.clear_clock(d);
        chk_byte("clr0", 8'h10, d);
        rchk(HIA_OFS_VIEW0, 8'h00);
        chk_bit("alert_n", 1'b1, alert_n);
    endtask

    // Event landing on the clearing edge must survive
    task automatic t_race;
        fire(6'h08);
        fork
            u_hia_host_model.rd(HIA_OFS_CLR0, d);
            fire(6'h08);
        join
        chk_byte("clr0", 8'h01, d);
        rchk(HIA_OFS_VIEW0, 8'h01);
        rchk(HIA_OFS_CLR0, 8'h01);
    endtask

    // Masks gate the alert, not the flags; read-only places ignore writes
    task automatic t_mask;
        u_hia_host_model.wr(HIA_OFS_MASK0, 8'h00);
        rchk(HIA_OFS_MASK0, 8'hc6);
        fire(6'h08);
        settle(1);
        chk_bit("alert_n", 1'b1, alert_n);
        u_hia_host_model.wr(HIA_OFS_MASK0, 8'hdf);
        rchk(HIA_OFS_MASK0, 8'hdf);
        chk_bit("alert_n", 1'b0, alert_n);
        u_hia_host_model.wr(HIA_OFS_CLR0, 8'h00);
        rchk(HIA_OFS_CLR0, 8'h01);
        u_hia_host_model.wr(HIA_OFS_MASK1, 8'h00);
        rchk(HIA_OFS_MASK1, 8'h00);
        fire(6'h01);
        settle(1);
        chk_bit("alert_n", 1'b1, alert_n);
        rchk(HIA_OFS_CLR1, 8'h04);
        u_hia_host_model.wr(HIA_OFS_MASK1, 8'hff);
        rchk(HIA_OFS_MASK1, 8'h1c);
    endtask

    // Initialisation done flags once on its rising edge
    task automatic t_init;
        @(posedge clk);
        init_done <= 1'b1;
        settle(2);
        chk_bit("alert_n", 1'b0, alert_n);
        rchk(HIA_OFS_CLR1, 8'h10);
        rchk(HIA_OFS_VIEW1, 8'h00);
        chk_bit("alert_n", 1'b1, alert_n);
    endtask

    // Copy follows only enabled clock events and pins their flags
    task automatic t_copy;
        fire(6'h10);
        settle(1);
        chk_bit("alert_n", 1'b0, alert_n);
        rchk(HIA_OFS_LPCOPY, 8'h08);
        rchk(HIA_OFS_CLR0, 8'h08);
        rchk(HIA_OFS_VIEW0, 8'h08);
        u_hia_host_model.clear_clock(d);
        chk_byte("clr0", 8'h08, d);
        rchk(HIA_OFS_VIEW0, 8'h00);
        u_hia_host_model.wr(HIA_OFS_MASK0, 8'h09);
        fire(6'h20);
        settle(1);
        chk_bit("alert_n", 1'b1, alert_n);
        rchk(HIA_OFS_LPCOPY, 8'h00);
        rchk(HIA_OFS_CLR0, 8'h10);
        rchk(HIA_OFS_VIEW0, 8'h00);
    endtask

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        events = '0;
        init_done = 1'b0;
        fail_count = 0;
        n_checks = 0;
        repeat (16) @(posedge clk);
        chk_bit("alert_n", 1'b1, alert_n);
        rst_n <= 1'b1;
        settle(1);
        t_reset;
        t_sources;
        t_alarm;
        t_race;
        t_mask;
        t_init;
        t_copy;
        test_done;
    end

    // Hang guard
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        test_done;
    end
endmodule
